// ---- core/dsc_device.sv ----
// Purpose: Synthesizer end: serial slave, register bank, channel cores
// Assumes: Link pins are asynchronous to sys_clk, sclk half period >= 4 cycles
// Notes: Reads of shared words return the first enabled channel's pending word
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// [R01] Reset leaves device in single-tone mode
// [R02] Shared word addresses write all enabled channels
// [R03] Channel enables act right after data byte
// [R04] All channel enables set after reset
// [R05] Reset: single-bit serial, words cleared
// [R06] Words reach outputs only on update
// [R07] Host writes one channel at a time
// [R08] Matched pipeline delay in single-tone only
// [R09] Multiplier is five bits 22:18
// [R10] Factor 4 to 20 enables multiplier
// [R11] Other factors bypass the multiplier
// [R12] Host waits lock time after multiplier change
// [R13] VCO range bit resets low, host matches
// [R14] Host keeps PLL output 100 to 500
// [R15] Charge pump resets to 75 uA
// [R16] Mode pin picks crystal or input buffer
// [R17] Pending words copied together on update
// [R18] 32-bit accumulator advances by active word
// [R19] 14-bit offset added before amplitude lookup
module dsc_device
    import dsc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    dsc_if.device link,
    input wire logic clk_mode_sel,
    output logic [NUM_CH-1:0] channel_enable,
    output logic single_tone,
    output logic matched_active,
    output logic pll_enable,
    output logic [4:0] sysclk_mult,
    output logic vco_high,
    output logic [1:0] charge_pump,
    output logic xtal_osc_en,
    output logic input_buf_en,
    output logic [NUM_CH-1:0][POW_W-1:0] ch_phase
);
    // Pin synchronisers: sclk, cs_b, sdio, io_update, master_reset, mode
    logic [5:0] meta_ff;
    logic [5:0] sync_ff;
    logic [5:0] prev_ff;
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            meta_ff <= 6'h02;
            sync_ff <= 6'h02;
            prev_ff <= 6'h02;
        end
        else
        begin
            meta_ff <= {clk_mode_sel, link.master_reset, link.io_update, link.sdio,
                link.cs_b, link.sclk};
            sync_ff <= meta_ff;
            prev_ff <= sync_ff;
        end
    end

    logic sclk_rise;
    logic frame_on;
    logic update_rise;
    logic soft_rst;
    assign sclk_rise = sync_ff[0] & ~prev_ff[0];
    assign frame_on = ~sync_ff[1];
    assign update_rise = sync_ff[3] & ~prev_ff[3];
    assign soft_rst = sync_ff[4];

    // Serial receive: instruction byte then data bytes
    logic [5:0] bit_cnt_ff;
    logic [31:0] shift_ff;
    logic [7:0] instr_ff;
    logic instr_done_ff;
    logic [5:0] frame_bits;
    logic wr_stb;
    logic rd_load;
    assign frame_bits = {dsc_nbytes(instr_ff[4:0]), 3'b000};
    assign rd_load = sclk_rise & frame_on & ~instr_done_ff & (bit_cnt_ff == 6'd7);
    assign wr_stb = sclk_rise & frame_on & instr_done_ff & ~instr_ff[INSTR_READ_BIT]
        & (bit_cnt_ff == frame_bits - 6'd1);
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            bit_cnt_ff <= 6'd0;
            shift_ff <= 32'h0000_0000;
            instr_ff <= 8'h00;
            instr_done_ff <= 1'b0;
        end
        else if (!frame_on)
        begin
            // Frame end drops any partial byte
            bit_cnt_ff <= 6'd0;
            instr_done_ff <= 1'b0;
        end
        else if (sclk_rise)
        begin
            shift_ff <= {shift_ff[30:0], sync_ff[2]};
            if (rd_load)
            begin
                instr_ff <= {shift_ff[6:0], sync_ff[2]};
                instr_done_ff <= 1'b1;
                bit_cnt_ff <= 6'd0;
            end
            else if (instr_done_ff && bit_cnt_ff == frame_bits - 6'd1)
            begin
                // Back-to-back frames without cs_b toggle start over
                instr_done_ff <= 1'b0;
                bit_cnt_ff <= 6'd0;
            end
            else
            begin
                bit_cnt_ff <= bit_cnt_ff + 6'd1;
            end
        end
    end

    logic [31:0] wr_data;
    logic [4:0] wr_addr;
    assign wr_data = {shift_ff[30:0], sync_ff[2]};
    assign wr_addr = instr_ff[4:0];

    // Control registers; master reset pin acts like power-on reset
    logic [7:0] csr_ff;
    logic [23:0] fr1_ff;
    logic [23:0] cfr_ff;
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            csr_ff <= CSR_RESET; // [R04] [R05]
            fr1_ff <= FR1_RESET; // [R13] [R15]
            cfr_ff <= CFR_RESET; // [R01]
        end
        else if (soft_rst)
        begin
            csr_ff <= CSR_RESET; // [R04] [R05]
            fr1_ff <= FR1_RESET;
            cfr_ff <= CFR_RESET; // [R01]
        end
        else if (wr_stb)
        begin
            // Channel enables change now, no update needed [R03]
            if (wr_addr == ADDR_CHAN_SEL)
                csr_ff <= wr_data[7:0];
            if (wr_addr == ADDR_FCFG_ONE)
                fr1_ff <= wr_data[23:0];
            if (wr_addr == ADDR_CHAN_FUNC)
                cfr_ff <= wr_data[23:0];
        end
    end

    assign channel_enable = csr_ff[CSR_CH0_EN_BIT +: NUM_CH];
    // Only single-tone is built; other modes just leave the flag low
    assign single_tone = (cfr_ff[CFR_AFP_LSB +: 2] == 2'b00) & ~cfr_ff[CFR_SWEEP_BIT]; // [R01]
    assign matched_active = single_tone & cfr_ff[CFR_MATCH_BIT]; // [R08]

    // Clock multiplier decode
    logic [4:0] mult;
    assign mult = fr1_ff[FR1_MULT_LSB +: 5]; // [R09]
    assign pll_enable = (mult >= MULT_MIN) && (mult <= MULT_MAX); // [R10]
    assign sysclk_mult = pll_enable ? mult : 5'd1; // [R10] [R11]
    assign vco_high = fr1_ff[FR1_VCO_BIT]; // [R13]
    assign charge_pump = fr1_ff[FR1_CP_LSB +: 2]; // [R15]
    assign xtal_osc_en = sync_ff[5]; // [R16]
    assign input_buf_en = ~sync_ff[5]; // [R16]

    // Per-channel pending, active words and phase path
    logic [31:0] pend_ftw_ff [NUM_CH];
    logic [POW_W-1:0] pend_pow_ff [NUM_CH];
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++)
        begin : g_ch
            logic [31:0] act_ftw_ff;
            logic [POW_W-1:0] act_pow_ff;
            logic [POW_W-1:0] pow_dly_ff;
            logic [31:0] acc_ff;
            logic [POW_W-1:0] ph_ff;
            // Pending words follow shared address writes
            always_ff @(posedge sys_clk or negedge rst_b)
            begin
                if (!rst_b)
                begin
                    pend_ftw_ff[g] <= FTW_RESET;
                    pend_pow_ff[g] <= POW_RESET;
                end
                else if (soft_rst)
                begin
                    pend_ftw_ff[g] <= FTW_RESET; // [R05]
                    pend_pow_ff[g] <= POW_RESET; // [R05]
                end
                else if (wr_stb && channel_enable[g])
                begin
                    if (wr_addr == ADDR_FTW)
                        pend_ftw_ff[g] <= wr_data; // [R02] [R17]
                    if (wr_addr == ADDR_POW)
                        pend_pow_ff[g] <= wr_data[POW_W-1:0]; // [R02] [R17]
                end
            end
            // Active words move only on io_update, all channels at once
            always_ff @(posedge sys_clk or negedge rst_b)
            begin
                if (!rst_b)
                begin
                    act_ftw_ff <= FTW_RESET;
                    act_pow_ff <= POW_RESET;
                end
                else if (soft_rst)
                begin
                    act_ftw_ff <= FTW_RESET; // [R05]
                    act_pow_ff <= POW_RESET; // [R05]
                end
                else if (update_rise)
                begin
                    act_ftw_ff <= pend_ftw_ff[g]; // [R06] [R17]
                    act_pow_ff <= pend_pow_ff[g]; // [R06] [R17]
                end
            end
            // Accumulator and offset; matched mode delays the offset path
            // by the accumulator's one stage so both changes land together
            always_ff @(posedge sys_clk or negedge rst_b)
            begin
                if (!rst_b)
                begin
                    acc_ff <= 32'h0000_0000;
                    pow_dly_ff <= POW_RESET;
                    ph_ff <= POW_RESET;
                end
                else if (soft_rst)
                begin
                    acc_ff <= 32'h0000_0000;
                    pow_dly_ff <= POW_RESET;
                    ph_ff <= POW_RESET;
                end
                else
                begin
                    acc_ff <= acc_ff + act_ftw_ff; // [R18]
                    pow_dly_ff <= act_pow_ff;
                    ph_ff <= acc_ff[31 -: POW_W]
                        + (matched_active ? pow_dly_ff : act_pow_ff); // [R19] [R08]
                end
            end
            assign ch_phase[g] = ph_ff;
        end
    endgenerate

    // Read-back shifter, loaded when the instruction byte completes
    logic [31:0] rd_val;
    logic rd_sel;
    logic [31:0] tx_ff;
    assign rd_sel = ~channel_enable[0];
    always_comb
    begin
        case ({shift_ff[3:0], sync_ff[2]})
            ADDR_CHAN_SEL: rd_val = {csr_ff, 24'h00_0000};
            ADDR_FCFG_ONE: rd_val = {fr1_ff, 8'h00};
            ADDR_CHAN_FUNC: rd_val = {cfr_ff, 8'h00};
            ADDR_FTW: rd_val = pend_ftw_ff[rd_sel];
            ADDR_POW: rd_val = {2'b00, pend_pow_ff[rd_sel], 16'h0000};
            default: rd_val = 32'h0000_0000;
        endcase
    end
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            tx_ff <= 32'h0000_0000;
        else if (rd_load)
            tx_ff <= shift_ff[6] ? rd_val : 32'h0000_0000;
        else if (sclk_rise && frame_on)
            tx_ff <= {tx_ff[30:0], 1'b0};
    end
    assign link.sdo = tx_ff[31];
endmodule
`default_nettype wire

// ---- common/dsc_pkg.sv ----
// Purpose: Shared constants for the two-channel tone synthesizer control link
// Assumes: 25 MHz sys_clk on both ends, single-bit serial framing
// Notes: Frame is one instruction byte then 1..4 data bytes, MSB first
package dsc_pkg;
    // Register addresses
    localparam logic [4:0] ADDR_CHAN_SEL = 5'h00;
    localparam logic [4:0] ADDR_FCFG_ONE = 5'h01;
    localparam logic [4:0] ADDR_CHAN_FUNC = 5'h03;
    localparam logic [4:0] ADDR_FTW = 5'h04;
    localparam logic [4:0] ADDR_POW = 5'h05;
    // Instruction byte fields
    localparam int INSTR_READ_BIT = 7;
    // Channel select fields
    localparam int CSR_CH0_EN_BIT = 6;
    localparam int CSR_SER_MODE_LSB = 1;
    localparam logic [7:0] CSR_RESET = 8'hC0;
    // Function config one fields
    localparam int FR1_VCO_BIT = 23;
    localparam int FR1_MULT_LSB = 18;
    localparam int FR1_CP_LSB = 16;
    localparam logic [23:0] FR1_RESET = 24'h00_0000;
    localparam logic [1:0] CP_75UA = 2'h0;
    localparam logic [4:0] MULT_MIN = 5'h04;
    localparam logic [4:0] MULT_MAX = 5'h14;
    // Channel function fields
    localparam int CFR_AFP_LSB = 22;
    localparam int CFR_SWEEP_BIT = 14;
    localparam int CFR_MATCH_BIT = 5;
    localparam logic [23:0] CFR_RESET = 24'h00_0000;
    localparam logic [31:0] FTW_RESET = 32'h0000_0000;
    localparam logic [13:0] POW_RESET = 14'h0000;
    localparam int NUM_CH = 2;
    localparam int POW_W = 14;
    // Timing
    localparam int SYS_CLK_KHZ = 25000;
    localparam int HALF_BIT_CYC = 8;
    localparam int LOCK_TIME_US = 1000;
    localparam int LOCK_CYC = (LOCK_TIME_US * SYS_CLK_KHZ) / 1000;
    localparam int PLL_MIN_MHZ = 100;
    localparam int PLL_MAX_MHZ = 500;
    localparam int VCO_SPLIT_MHZ = 255;
    // Host command kinds
    typedef enum logic [1:0] {
        DSC_CMD_WRITE = 2'b00,
        DSC_CMD_READ = 2'b01,
        DSC_CMD_UPDATE = 2'b10,
        DSC_CMD_RESET = 2'b11
    } dsc_cmd_t;
    // Data bytes that follow the instruction for an address
    function automatic logic [2:0] dsc_nbytes(input logic [4:0] addr);
        case (addr)
            ADDR_CHAN_SEL: dsc_nbytes = 3'd1;
            ADDR_FCFG_ONE: dsc_nbytes = 3'd3;
            ADDR_CHAN_FUNC: dsc_nbytes = 3'd3;
            ADDR_FTW: dsc_nbytes = 3'd4;
            ADDR_POW: dsc_nbytes = 3'd2;
            default: dsc_nbytes = 3'd1;
        endcase
    endfunction
endpackage

// ---- common/dsc_if.sv ----
// Purpose: Serial programming link between host controller and synthesizer
// Assumes: Host makes sclk from its own clock; device samples all pins
// Notes: sdo is a dedicated read-back line, no two-way pins
`timescale 1ns/1ps
`default_nettype none
interface dsc_if;
    logic sclk;
    logic cs_b;
    logic sdio;
    logic sdo;
    logic io_update;
    logic master_reset;
    modport device (input sclk, input cs_b, input sdio, input io_update,
        input master_reset, output sdo);
    modport host (output sclk, output cs_b, output sdio, output io_update,
        output master_reset, input sdo);
endinterface
`default_nettype wire

// ---- core/dsc_host.sv ----
// Purpose: Host end: turns user commands into serial frames and strobes
// Assumes: REF_MHZ gives the reference clock so PLL range can be checked
// Notes: sclk is divided from sys_clk; cmd_ready stalls during lock wait
`timescale 1ns/1ps
`default_nettype none
module dsc_host
    import dsc_pkg::*;
#(
    parameter int LOCK_CYCLES = LOCK_CYC,
    parameter int REF_MHZ = 25
)
(
    input wire logic sys_clk,
    input wire logic rst_b,
    dsc_if.host link,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic [1:0] cmd_kind,
    input wire logic [4:0] cmd_addr,
    input wire logic [31:0] cmd_data,
    output logic cmd_error,
    output logic rsp_valid,
    output logic [31:0] rsp_data
);
    typedef enum logic [1:0] {
        HST_IDLE = 2'b00,
        HST_SHIFT = 2'b01,
        HST_PULSE = 2'b10,
        HST_LOCK = 2'b11
    } dsc_hst_t;

    dsc_hst_t state_ff;
    logic [15:0] div_ff;
    logic [24:0] wait_ff;
    logic [5:0] bits_ff;
    logic [39:0] out_ff;
    logic [31:0] rx_ff;
    logic rd_ff;
    logic fr1_ff;
    logic sclk_ff;
    logic cs_b_ff;
    logic upd_ff;
    logic mrst_ff;
    logic err_ff;
    logic rsp_ff;
    logic [31:0] rsp_data_ff;

    // Multiplier range check and VCO range choice
    logic [4:0] m;
    logic m_on;
    logic [15:0] f_mhz;
    logic bad_pll;
    logic [31:0] wdata;
    assign m = cmd_data[FR1_MULT_LSB +: 5];
    assign m_on = (m >= MULT_MIN) && (m <= MULT_MAX);
    assign f_mhz = 16'(REF_MHZ) * {11'd0, m};
    assign bad_pll = m_on && ((f_mhz < 16'(PLL_MIN_MHZ)) || (f_mhz > 16'(PLL_MAX_MHZ))); // [R14]
    always_comb
    begin
        wdata = cmd_data;
        if (cmd_addr == ADDR_FCFG_ONE)
            wdata[FR1_VCO_BIT] = m_on && (f_mhz > 16'(VCO_SPLIT_MHZ)); // [R13]
    end

    assign cmd_ready = (state_ff == HST_IDLE);
    logic take;
    logic refuse;
    logic [5:0] nbits;
    assign take = cmd_valid & cmd_ready;
    assign refuse = (dsc_cmd_t'(cmd_kind) == DSC_CMD_WRITE) && (cmd_addr == ADDR_FCFG_ONE)
        && bad_pll;
    assign nbits = {dsc_nbytes(cmd_addr), 3'b000} + 6'd8;

    // Sequencer: frames, strobes and lock wait
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_ff <= HST_IDLE;
            div_ff <= 16'h0000;
            wait_ff <= 25'd0;
            bits_ff <= 6'd0;
            out_ff <= 40'h00_0000_0000;
            rx_ff <= 32'h0000_0000;
            rd_ff <= 1'b0;
            fr1_ff <= 1'b0;
            sclk_ff <= 1'b0;
            cs_b_ff <= 1'b1;
            upd_ff <= 1'b0;
            mrst_ff <= 1'b0;
            err_ff <= 1'b0;
            rsp_ff <= 1'b0;
            rsp_data_ff <= 32'h0000_0000;
        end
        else
        begin
            err_ff <= 1'b0;
            rsp_ff <= 1'b0;
            case (state_ff)
                HST_IDLE:
                begin
                    div_ff <= 16'h0000;
                    if (take && refuse)
                        err_ff <= 1'b1;
                    else if (take && cmd_kind[1])
                    begin
                        // Update or reset pin held for one bit time
                        upd_ff <= (dsc_cmd_t'(cmd_kind) == DSC_CMD_UPDATE);
                        mrst_ff <= (dsc_cmd_t'(cmd_kind) == DSC_CMD_RESET);
                        state_ff <= HST_PULSE;
                    end
                    else if (take)
                    begin
                        rd_ff <= cmd_kind[0];
                        fr1_ff <= ~cmd_kind[0] && (cmd_addr == ADDR_FCFG_ONE);
                        // Data left-justified so its first byte leads
                        out_ff <= {cmd_kind[0], 2'b00, cmd_addr, wdata << (6'd40 - nbits)};
                        bits_ff <= nbits;
                        rx_ff <= 32'h0000_0000;
                        cs_b_ff <= 1'b0;
                        state_ff <= HST_SHIFT;
                    end
                end
                HST_SHIFT:
                begin
                    div_ff <= div_ff + 16'h0001;
                    if (div_ff == 16'(HALF_BIT_CYC - 1))
                    begin
                        sclk_ff <= 1'b1;
                        rx_ff <= {rx_ff[30:0], link.sdo};
                    end
                    else if (div_ff == 16'(2 * HALF_BIT_CYC - 1))
                    begin
                        div_ff <= 16'h0000;
                        sclk_ff <= 1'b0;
                        out_ff <= {out_ff[38:0], 1'b0};
                        bits_ff <= bits_ff - 6'd1;
                        if (bits_ff == 6'd1)
                        begin
                            cs_b_ff <= 1'b1;
                            rsp_ff <= rd_ff;
                            rsp_data_ff <= rx_ff;
                            // Hold off new commands while the PLL relocks [R12]
                            wait_ff <= 25'(LOCK_CYCLES);
                            state_ff <= fr1_ff ? HST_LOCK : HST_IDLE;
                        end
                    end
                end
                HST_PULSE:
                begin
                    div_ff <= div_ff + 16'h0001;
                    if (div_ff == 16'(2 * HALF_BIT_CYC - 1))
                    begin
                        upd_ff <= 1'b0;
                        mrst_ff <= 1'b0;
                        state_ff <= HST_IDLE;
                    end
                end
                HST_LOCK:
                begin
                    wait_ff <= wait_ff - 25'd1;
                    if (wait_ff <= 25'd1)
                        state_ff <= HST_IDLE; // [R12]
                end
                default: state_ff <= HST_IDLE;
            endcase
        end
    end

    assign link.sclk = sclk_ff;
    assign link.cs_b = cs_b_ff;
    assign link.sdio = out_ff[39];
    assign link.io_update = upd_ff; // [R07]
    assign link.master_reset = mrst_ff;
    assign cmd_error = err_ff;
    assign rsp_valid = rsp_ff;
    assign rsp_data = rsp_data_ff;
endmodule
`default_nettype wire

// ---- test/dsc_properties.sv ----
// Purpose: Concurrent checks on the link and device decodes
// Assumes: One sys_clk domain, rst_b active low
// Notes: Instantiated beside the interface, no bind
`timescale 1ns/1ps
`default_nettype none
module dsc_properties
    import dsc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic sclk,
    input wire logic cs_b,
    input wire logic io_update,
    input wire logic master_reset,
    input wire logic clk_mode_sel,
    input wire logic [NUM_CH-1:0] channel_enable,
    input wire logic single_tone,
    input wire logic matched_active,
    input wire logic pll_enable,
    input wire logic [4:0] sysclk_mult,
    input wire logic vco_high,
    input wire logic [1:0] charge_pump,
    input wire logic xtal_osc_en,
    input wire logic input_buf_en
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    // Reset values seen at the first edge after release
    a_reset_enables: assert property ($rose(rst_b) |-> channel_enable == 2'b11 && single_tone)
        else $error("enables or mode wrong after reset");
    a_reset_pump_vco: assert property ($rose(rst_b) |-> !vco_high && charge_pump == 2'h0)
        else $error("pll settings wrong after reset");
    // Multiplier decode, both branches
    a_mult_window: assert property (pll_enable |-> sysclk_mult inside {[5'h04:5'h14]})
        else $error("multiplier enabled outside window");
    a_bypass_unity: assert property (!pll_enable |-> sysclk_mult == 5'h01)
        else $error("bypass factor not one");
    a_matched_gate: assert property (matched_active |-> single_tone)
        else $error("matched delay outside single tone");
    // Two sync flops, so four stable samples leave margin
    a_mode_xtal: assert property (clk_mode_sel [*4] |-> xtal_osc_en && !input_buf_en)
        else $error("crystal mode not selected");
    a_mode_buffer: assert property (!clk_mode_sel [*4] |-> input_buf_en && !xtal_osc_en)
        else $error("input buffer mode not selected");
    a_soft_restore: assert property (master_reset [*5] |-> channel_enable == 2'b11 && !pll_enable)
        else $error("soft reset did not restore");
    // Serial clock only moves inside a frame
    a_sclk_framed: assert property (sclk |-> !cs_b)
        else $error("serial clock outside frame");
    a_update_width: assert property ($rose(io_update) |-> io_update [*8])
        else $error("update strobe too short");
endmodule
`default_nettype wire

// ---- test/tb_top.sv ----
// Purpose: Host and device joined by the link, driven from the host user port
// Assumes: Short lock count, 25 MHz reference
// Notes: Phase advance is checked as a one-cycle step of ch_phase
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import dsc_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic clk_mode_sel = 1'b0;
    logic cmd_valid = 1'b0;
    logic cmd_ready;
    logic [1:0] cmd_kind = 2'h0;
    logic [4:0] cmd_addr = 5'h00;
    logic [31:0] cmd_data = 32'h0000_0000;
    logic cmd_error;
    logic rsp_valid;
    logic [31:0] rsp_data;
    logic [NUM_CH-1:0] channel_enable;
    logic single_tone, matched_active, pll_enable, vco_high, xtal_osc_en, input_buf_en;
    logic [4:0] sysclk_mult;
    logic [1:0] charge_pump;
    logic [NUM_CH-1:0][POW_W-1:0] ch_phase;
    logic [31:0] rdata, f, g;
    logic [13:0] p0, p1;
    logic [4:0] mt [7] = '{5'h00, 5'h03, 5'h04, 5'h14, 5'h15, 5'h1f, 5'h0a};
    int mismatches = 0;
    int comparisons = 0;
    dsc_if link();
    dsc_host #(.LOCK_CYCLES(20), .REF_MHZ(25)) u_dsc_host (.sys_clk(sys_clk), .rst_b(rst_b),
        .link(link), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_kind(cmd_kind),
        .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_error(cmd_error),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data));
    dsc_device u_dsc_device (.sys_clk(sys_clk), .rst_b(rst_b), .link(link),
        .clk_mode_sel(clk_mode_sel), .channel_enable(channel_enable), .single_tone(single_tone),
        .matched_active(matched_active), .pll_enable(pll_enable), .sysclk_mult(sysclk_mult),
        .vco_high(vco_high), .charge_pump(charge_pump), .xtal_osc_en(xtal_osc_en),
        .input_buf_en(input_buf_en), .ch_phase(ch_phase));
    dsc_properties u_dsc_properties (.sys_clk(sys_clk), .rst_b(rst_b), .sclk(link.sclk),
        .cs_b(link.cs_b), .io_update(link.io_update), .master_reset(link.master_reset),
        .clk_mode_sel(clk_mode_sel), .channel_enable(channel_enable), .single_tone(single_tone),
        .matched_active(matched_active), .pll_enable(pll_enable), .sysclk_mult(sysclk_mult),
        .vco_high(vco_high), .charge_pump(charge_pump), .xtal_osc_en(xtal_osc_en),
        .input_buf_en(input_buf_en));
    // 40 ns period
    initial
    begin
        forever #20 sys_clk = ~sys_clk;
    end
    task automatic final_report();
        $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Entered at a falling edge with ready high; waits for ready again
    task automatic send(input logic [1:0] k, input logic [4:0] a, input logic [31:0] d);
        int n;
        cmd_kind = k;
        cmd_addr = a;
        cmd_data = d;
        cmd_valid = 1'b1;
        @(negedge sys_clk);
        cmd_valid = 1'b0;
        chk(cmd_error, 1'b0);
        for (n = 0; n < 3000; n++)
        begin
            @(negedge sys_clk);
            if (rsp_valid === 1'b1)
                rdata = rsp_data;
            if (cmd_ready === 1'b1)
                break;
        end
        if (n == 3000)
        begin
            mismatches++;
            final_report();
        end
        repeat (6) @(negedge sys_clk);
    endtask
    // Accumulator step gives ftw[31:18] or one more, before the offset
    task automatic chk_adv(input int c, input logic [31:0] w);
        logic [13:0] a;
        logic [13:0] d;
        a = ch_phase[c];
        @(negedge sys_clk);
        d = ch_phase[c] - a;
        chk({18'h0, d}, (d === w[31:18] + 14'h1) ? {18'h0, d} : {18'h0, w[31:18]});
    endtask
    initial
    begin
        void'($urandom(32'hc8c0_dfe1));
        repeat (2) @(negedge sys_clk);
        rst_b = 1'b1;
        repeat (4) @(negedge sys_clk);
        // Reset state
        chk({pll_enable, vco_high, charge_pump, sysclk_mult}, {4'h0, 5'h01});
        send(DSC_CMD_READ, ADDR_CHAN_SEL, 32'h0);
        chk(rdata[7:0], CSR_RESET);
        send(DSC_CMD_READ, ADDR_FTW, 32'h0);
        chk(rdata, FTW_RESET);
        send(DSC_CMD_READ, 5'h02, 32'h0);
        chk(rdata[7:0], 8'h00);
        $display("reset test done");
        // Shared words reach both channels after update; only channel 0 is checked for no advance before it
        f = $urandom;
        send(DSC_CMD_WRITE, ADDR_FTW, f);
        send(DSC_CMD_READ, ADDR_FTW, 32'h0);
        chk(rdata, f);
        chk_adv(0, 32'h0);
        send(DSC_CMD_UPDATE, 5'h00, 32'h0);
        chk_adv(0, f);
        chk_adv(1, f);
        $display("shared test done");
        // One channel at a time
        p0 = 14'($urandom);
        p1 = 14'($urandom);
        send(DSC_CMD_WRITE, ADDR_CHAN_SEL, 32'h40);
        chk(channel_enable, 2'b01);
        send(DSC_CMD_WRITE, ADDR_POW, {18'h0, p0});
        send(DSC_CMD_WRITE, ADDR_CHAN_SEL, 32'h80);
        chk(channel_enable, 2'b10);
        send(DSC_CMD_WRITE, ADDR_POW, {18'h0, p1});
        send(DSC_CMD_READ, ADDR_POW, 32'h0);
        chk(rdata[13:0], p1);
        send(DSC_CMD_UPDATE, 5'h00, 32'h0);
        chk({18'h0, ch_phase[1] - ch_phase[0]}, {18'h0, p1 - p0});
        g = $urandom;
        send(DSC_CMD_WRITE, ADDR_FTW, g);
        chk_adv(1, f);
        send(DSC_CMD_UPDATE, 5'h00, 32'h0);
        chk_adv(0, f);
        chk_adv(1, g);
        $display("per channel test done");
        // Multiplier corners plus one random legal factor
        mt[6] = 5'($urandom_range(20, 4));
        foreach (mt[i])
        begin
            p0[1:0] = 2'($urandom);
            send(DSC_CMD_WRITE, ADDR_FCFG_ONE, {9'h0, mt[i], p0[1:0], 16'h0});
            chk(pll_enable, mt[i] inside {[5'h04:5'h14]});
            chk(sysclk_mult, (mt[i] inside {[5'h04:5'h14]}) ? mt[i] : 5'h01);
            chk(charge_pump, p0[1:0]);
            if (mt[i] inside {[5'h04:5'h14]})
                chk(vco_high, mt[i] * 25 > VCO_SPLIT_MHZ);
        end
        $display("multiplier test done");
        // Matched delay and mode decode
        send(DSC_CMD_WRITE, ADDR_CHAN_FUNC, 32'h0000_0020);
        chk({single_tone, matched_active}, 2'b11);
        send(DSC_CMD_WRITE, ADDR_CHAN_FUNC, 32'h0040_0020);
        chk({single_tone, matched_active}, 2'b00);
        clk_mode_sel = 1'b1;
        repeat (4) @(negedge sys_clk);
        chk({xtal_osc_en, input_buf_en}, 2'b10);
        clk_mode_sel = 1'b0;
        repeat (4) @(negedge sys_clk);
        chk({xtal_osc_en, input_buf_en}, 2'b01);
        $display("mode test done");
        // Soft reset in mid-run
        send(DSC_CMD_RESET, 5'h00, 32'h0);
        chk({channel_enable, single_tone, pll_enable}, 4'b1110);
        send(DSC_CMD_READ, ADDR_FTW, 32'h0);
        chk(rdata, 32'h0);
        send(DSC_CMD_UPDATE, 5'h00, 32'h0);
        chk_adv(0, 32'h0);
        $display("soft reset test done");
        final_report();
    end
endmodule
`default_nettype wire
